// *** core/zolu_core.sv ***
// Behaviour
// - Four-entry buffer serves short loop bodies.
// - Longer bodies prefetch past buffer on loopback.
// - Nonzero start offset: first loopback stalls four.
// - Any instruction allowed at loop bottom.
// - Two units, each count, top, bottom.
// - Unit zero outer, unit one inner.
// - Inner loopback suppresses outer on shared bottom.
// - Counter write reinitialises, ten-cycle replay.
// - Address write single cycle when count zero.
// - Address write with live count: replay.
// - Each register writable alone; count writes always reinitialise.
// - Bottom match: loop if count>=2, decrement.
// - Zero count disables loopback.
// - Setup loads bottom, top and count.
// - Counters are unsigned 32-bit.
`timescale 1ns/1ps
`default_nettype none
`include "zolu_defines.svh"
module zolu_core (
	input  wire logic                 MCLK_IN,
	input  wire logic                 RESET_N_IN,
	input  wire logic                 WB_CYC_IN,
	input  wire logic                 WB_STB_IN,
	input  wire logic                 WB_WE_IN,
	input  wire logic [7:0]           WB_ADR_IN,
	input  wire logic [3:0]           WB_SEL_IN,
	input  wire logic [31:0]          WB_DAT_IN,
	output logic      [31:0]          WB_DAT_OUT,
	output logic                      WB_ACK_OUT,
	input  wire logic                 PC_VALID_IN,
	input  wire logic [31:0]          PC_IN,
	input  wire logic [31:0]          INSTR_IN,
	input  wire logic                 REDIRECT_IN,
	input  wire zolu_pkg::zolu_setup_s SETUP_IN,
	input  wire logic                 FETCH_REQ_IN,
	input  wire logic [31:0]          FETCH_ADDR_IN,
	output logic                      LOOPBACK_OUT,
	output logic      [31:0]          TARGET_OUT,
	output logic                      STALL_OUT,
	output logic                      BUF_HIT_OUT,
	output logic      [31:0]          BUF_DATA_OUT,
	output logic                      PREFETCH_OUT,
	output logic      [31:0]          PREFETCH_ADDR_OUT
);
	import zolu_pkg::*;

	function automatic logic can_loop(input logic m, input logic [31:0] c);
		return m && (c >= `ZOLU_CNT_LOOP);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] cnt [2];
	logic [31:0] top [2];
	logic [31:0] bot [2];
	logic [31:0] next_cnt [2];
	logic [31:0] next_top [2];
	logic [31:0] next_bot [2];
	logic [1:0]  first;
	logic [1:0]  next_first;
	logic [3:0]  stall_cnt;
	logic [3:0]  next_stall_cnt;
	logic [3:0]  stall_run;
	logic [3:0]  next_stall_run;
	zolu_state_e state;
	zolu_state_e next_state;
	logic        owner;
	logic        next_owner;
	logic [31:0] base;
	logic [31:0] next_base;
	logic [3:0]  bvld;
	logic [3:0]  next_bvld;
	logic [31:0] bdat [4];
	logic [31:0] next_bdat [4];
	logic        next_ack;
	logic [31:0] next_dat;
	logic        next_loop;
	logic [31:0] next_target;
	logic        next_pf;
	logic [31:0] next_pf_addr;
	logic        next_hit;
	logic [31:0] next_hdat;

	logic        ex;
	logic [1:0]  at_bot;
	logic [1:0]  take;
	logic [1:0]  dec;
	logic        inner_wins;
	logic        tu;
	logic        wr;
	logic        wu;
	zolu_kind_e  wk;
	logic        reinit;
	logic [31:0] rdat;
	logic [31:0] fd;
	logic [31:0] pd;
	logic        fhit;
	logic [31:0] fdat;

	// Pipeline holds off while a replay or first-loopback stall runs
	assign ex = PC_VALID_IN && !STALL_OUT;
	assign wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_ACK_OUT;

	always_comb begin
		wu = 1'b0;
		wk = ZK_NONE;
		case (WB_ADR_IN)
			`ZOLU_OFF_OCNT: begin wk = ZK_CNT; rdat = cnt[0]; end
			`ZOLU_OFF_OTOP: begin wk = ZK_TOP; rdat = top[0]; end
			`ZOLU_OFF_OBOT: begin wk = ZK_BOT; rdat = bot[0]; end
			`ZOLU_OFF_ICNT: begin wu = 1'b1; wk = ZK_CNT; rdat = cnt[1]; end
			`ZOLU_OFF_ITOP: begin wu = 1'b1; wk = ZK_TOP; rdat = top[1]; end
			`ZOLU_OFF_IBOT: begin wu = 1'b1; wk = ZK_BOT; rdat = bot[1]; end
			`ZOLU_OFF_STAT: rdat = {21'h0, state, first, bvld, owner, STALL_OUT, LOOPBACK_OUT};
			default: rdat = `ZOLU_RST_WORD;
		endcase
	end

	always_comb begin
		for (int u = 0; u < 2; u++) begin
			at_bot[u] = ex && (PC_IN == bot[u]);
		end
		inner_wins = can_loop(at_bot[1], cnt[1]);
		take[1] = inner_wins && !REDIRECT_IN;
		take[0] = can_loop(at_bot[0], cnt[0]) && !inner_wins && !REDIRECT_IN;
		dec[1] = at_bot[1] && (cnt[1] != `ZOLU_RST_WORD);
		dec[0] = at_bot[0] && (cnt[0] != `ZOLU_RST_WORD) && !inner_wins;
		tu = take[1];
		fd = FETCH_ADDR_IN - base;
		fhit = FETCH_REQ_IN && (fd < `ZOLU_BUF_SPAN) && bvld[fd[3:2]];
		fdat = bdat[fd[3:2]];
		pd = PC_IN - base;
	end

	always_comb begin
		next_cnt = cnt;
		next_top = top;
		next_bot = bot;
		next_first = first;
		next_owner = owner;
		next_base = base;
		next_bvld = bvld;
		next_bdat = bdat;
		reinit = 1'b0;
		next_ack = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
		next_dat = WB_ACK_OUT ? WB_DAT_OUT : rdat;
		for (int u = 0; u < 2; u++) begin
			if (dec[u]) begin
				next_cnt[u] = cnt[u] - 32'h1;
			end
		end
		if (ex && (pd < `ZOLU_BUF_SPAN) && (pd[1:0] == 2'b00)) begin
			next_bvld[pd[3:2]] = 1'b1;
			next_bdat[pd[3:2]] = INSTR_IN;
		end
		// Clear before setup, so a new loop's first flag wins a tie
		if (|take) begin
			next_first[tu] = 1'b0;
		end
		if (SETUP_IN.valid) begin
			next_cnt[SETUP_IN.unit] = SETUP_IN.count;
			next_top[SETUP_IN.unit] = SETUP_IN.top;
			next_bot[SETUP_IN.unit] = SETUP_IN.bottom;
			next_first[SETUP_IN.unit] = SETUP_IN.top != SETUP_IN.follow;
			next_owner = SETUP_IN.unit;
			next_base = SETUP_IN.top;
			next_bvld = 4'h0;
		end
		// Bus write lands after the sequencer's own update and wins
		if (wr) begin
			case (wk)
				ZK_CNT: begin
					next_cnt[wu] = merge(cnt[wu], WB_DAT_IN, WB_SEL_IN);
					reinit = 1'b1;
				end
				ZK_TOP: begin
					next_top[wu] = merge(top[wu], WB_DAT_IN, WB_SEL_IN);
					reinit = cnt[wu] != `ZOLU_RST_WORD;
				end
				ZK_BOT: begin
					next_bot[wu] = merge(bot[wu], WB_DAT_IN, WB_SEL_IN);
					reinit = cnt[wu] != `ZOLU_RST_WORD;
				end
				default: reinit = 1'b0;
			endcase
		end
		if (reinit) begin
			// Innermost live unit owns the refilled buffer
			next_owner = next_cnt[1] != `ZOLU_RST_WORD;
			next_base = next_top[next_owner];
			next_bvld = 4'h0;
		end
	end

	always_comb begin
		next_stall_cnt = (stall_cnt != 4'h0) ? stall_cnt - 4'h1 : 4'h0;
		next_state = (next_stall_cnt == 4'h0) ? ZS_RUN : state;
		if (|take && first[tu] && next_stall_cnt < `ZOLU_FIRST_CYC) begin
			next_stall_cnt = `ZOLU_FIRST_CYC;
			next_state = ZS_LATENCY;
		end
		if (reinit) begin
			next_stall_cnt = `ZOLU_REPLAY_CYC;
			next_state = ZS_REPLAY;
		end
		next_loop = |take;
		next_target = top[tu];
		// Body beyond the buffer: fetch the fifth word while buffer runs
		next_pf = take[owner] && (bot[owner] - top[owner] >= `ZOLU_BUF_SPAN);
		next_pf_addr = top[owner] + `ZOLU_BUF_SPAN;
		next_hit = fhit;
		next_hdat = fhit ? fdat : `ZOLU_RST_WORD;
		// Stall run length for the replay checks, saturating
		next_stall_run = STALL_OUT ? stall_run + {3'h0, stall_run != 4'hf} : 4'h0;
	end

	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			for (int u = 0; u < 2; u++) begin
				cnt[u] <= `ZOLU_RST_WORD;
				top[u] <= `ZOLU_RST_WORD;
				bot[u] <= `ZOLU_RST_WORD;
			end
			for (int i = 0; i < 4; i++) begin
				bdat[i] <= `ZOLU_RST_WORD;
			end
			first <= 2'b00;
			stall_cnt <= 4'h0;
			stall_run <= 4'h0;
			state <= ZS_RUN;
			owner <= 1'b0;
			base <= `ZOLU_RST_WORD;
			bvld <= 4'h0;
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= `ZOLU_RST_WORD;
			LOOPBACK_OUT <= 1'b0;
			TARGET_OUT <= `ZOLU_RST_WORD;
			STALL_OUT <= 1'b0;
			BUF_HIT_OUT <= 1'b0;
			BUF_DATA_OUT <= `ZOLU_RST_WORD;
			PREFETCH_OUT <= 1'b0;
			PREFETCH_ADDR_OUT <= `ZOLU_RST_WORD;
		end else begin
			cnt <= next_cnt;
			top <= next_top;
			bot <= next_bot;
			bdat <= next_bdat;
			first <= next_first;
			stall_cnt <= next_stall_cnt;
			stall_run <= next_stall_run;
			state <= next_state;
			owner <= next_owner;
			base <= next_base;
			bvld <= next_bvld;
			WB_ACK_OUT <= next_ack;
			WB_DAT_OUT <= next_dat;
			LOOPBACK_OUT <= next_loop;
			TARGET_OUT <= next_target;
			STALL_OUT <= next_stall_cnt != 4'h0;
			BUF_HIT_OUT <= next_hit;
			BUF_DATA_OUT <= next_hdat;
			PREFETCH_OUT <= next_pf;
			PREFETCH_ADDR_OUT <= next_pf_addr;
		end
	end

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	property p_inner_take;
		ex && PC_IN == bot[1] && cnt[1] >= 32'h2 && !REDIRECT_IN
			|=> LOOPBACK_OUT && TARGET_OUT == $past(top[1]);
	endproperty
	a_inner_take: assert property (p_inner_take) else $error("inner loopback missed");
	property p_prio;
		ex && PC_IN == bot[1] && cnt[1] >= 32'h2 && PC_IN == bot[0] && !wr && !SETUP_IN.valid
			&& !REDIRECT_IN
			|=> cnt[0] == $past(cnt[0]) && TARGET_OUT == $past(top[1]);
	endproperty
	a_prio: assert property (p_prio) else $error("outer unit not suppressed");
	property p_dec;
		ex && PC_IN == bot[1] && cnt[1] != 32'h0 && !wr && !SETUP_IN.valid
			|=> cnt[1] == $past(cnt[1]) - 32'h1;
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented");
	property p_zero;
		cnt[0] < 32'h2 && cnt[1] < 32'h2 |=> !LOOPBACK_OUT;
	endproperty
	a_zero: assert property (p_zero) else $error("loopback with low count");
	property p_replay;
		wr && wk == ZK_CNT |=> ##9 (STALL_OUT && stall_run >= 4'h9);
	endproperty
	a_replay: assert property (p_replay) else $error("counter write replay short");
	property p_quiet;
		wr && wk != ZK_CNT && cnt[wu] == 32'h0 && !STALL_OUT && !PC_VALID_IN |=> !STALL_OUT;
	endproperty
	a_quiet: assert property (p_quiet) else $error("idle address write stalled");
	property p_addr_replay;
		wr && wk inside {ZK_TOP, ZK_BOT} && cnt[wu] != 32'h0
			|=> ##9 (STALL_OUT && stall_run >= 4'h9);
	endproperty
	a_addr_replay: assert property (p_addr_replay) else $error("live address write no replay");
	property p_first;
		|take && first[tu] |=> STALL_OUT [*4] ##1 !first[$past(tu, 5)];
	endproperty
	a_first: assert property (p_first) else $error("first loopback latency wrong");
	property p_setup;
		SETUP_IN.valid && !wr |=> cnt[$past(SETUP_IN.unit)] == $past(SETUP_IN.count)
			&& bot[$past(SETUP_IN.unit)] == $past(SETUP_IN.bottom);
	endproperty
	a_setup: assert property (p_setup) else $error("setup load wrong");
	property p_hit;
		fhit |=> BUF_HIT_OUT && BUF_DATA_OUT == $past(fdat);
	endproperty
	a_hit: assert property (p_hit) else $error("buffer hit lost");

	c_inner: cover property (LOOPBACK_OUT && $past(take[1]));
	c_outer: cover property (take[0] && bot[0] == bot[1]);
	c_replay: cover property (state == ZS_REPLAY);
	c_hit: cover property (BUF_HIT_OUT);
endmodule
`default_nettype wire

// *** core/zolu_defines.svh ***
`ifndef ZOLU_DEFINES_SVH
`define ZOLU_DEFINES_SVH
`define ZOLU_OFF_OCNT   8'h00
`define ZOLU_OFF_OTOP   8'h04
`define ZOLU_OFF_OBOT   8'h08
`define ZOLU_OFF_ICNT   8'h0c
`define ZOLU_OFF_ITOP   8'h10
`define ZOLU_OFF_IBOT   8'h14
`define ZOLU_OFF_STAT   8'h18
`define ZOLU_RST_WORD   32'h0000_0000
`define ZOLU_CNT_LOOP   32'h0000_0002
`define ZOLU_BUF_SPAN   32'h0000_0010
`define ZOLU_REPLAY_CYC 4'ha
`define ZOLU_FIRST_CYC  4'h4
`endif

// *** core/zolu_pkg.sv ***
package zolu_pkg;
	typedef enum logic [1:0] {ZS_RUN, ZS_REPLAY, ZS_LATENCY} zolu_state_e;
	typedef enum logic [1:0] {ZK_CNT, ZK_TOP, ZK_BOT, ZK_NONE} zolu_kind_e;
	typedef struct packed {
		logic        valid;
		logic        unit;
		logic [31:0] top;
		logic [31:0] bottom;
		logic [31:0] count;
		logic [31:0] follow;
	} zolu_setup_s;
endpackage

// *** test/zolu_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module zolu_seq_model (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        go_in,
	input  wire logic [31:0] start_in,
	input  wire logic [31:0] end_in,
	input  wire logic        loopback_in,
	input  wire logic [31:0] target_in,
	input  wire logic        stall_in,
	output logic             pc_valid_out,
	output logic      [31:0] pc_out,
	output logic      [31:0] instr_out,
	output logic             done_out
);
	logic [31:0] seq;
	// Taken jump overrides the sequential address
	assign pc_out = loopback_in ? target_in : seq;
	assign done_out = go_in && (pc_out == end_in);
	assign pc_valid_out = go_in && !done_out;
	assign instr_out = pc_out ^ 32'ha5a5_0000;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			seq <= 32'h0;
		else if (!go_in)
			seq <= start_in;
		else if (pc_valid_out && !stall_in)
			seq <= pc_out + 32'h4;
		else if (loopback_in)
			seq <= target_in;
	end
endmodule
`default_nettype wire

// *** test/zolu_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module zolu_core_tb;
	import zolu_pkg::*;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, go = 0, freq = 0, redir = 0;
	logic [3:0] sel = 0;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rdat, tgt, pc, ins, fadr = 0, st = 0, en = 0;
	logic [31:0] bdat, pfa, lbt, pft;
	logic ack, lb, stall, hit, pf, pcv, done;
	zolu_setup_s su = '0;
	int miscompares = 0, n_compared = 0, ncyc = 0, lbn, stn, pfn;
	logic [31:0] q;
	always #4 clk = ~clk;
	zolu_core uut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PC_VALID_IN(pcv), .PC_IN(pc),
		.INSTR_IN(ins), .REDIRECT_IN(redir), .SETUP_IN(su), .FETCH_REQ_IN(freq),
		.FETCH_ADDR_IN(fadr), .LOOPBACK_OUT(lb), .TARGET_OUT(tgt), .STALL_OUT(stall),
		.BUF_HIT_OUT(hit), .BUF_DATA_OUT(bdat), .PREFETCH_OUT(pf),
		.PREFETCH_ADDR_OUT(pfa));
	zolu_seq_model seqm (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .start_in(st),
		.end_in(en), .loopback_in(lb), .target_in(tgt), .stall_in(stall),
		.pc_valid_out(pcv), .pc_out(pc), .instr_out(ins), .done_out(done));
	always @(posedge clk) begin
		ncyc++;
		if (stall === 1'b1) stn++;
		// Targets are caught while their pulse stands
		if (lb === 1'b1) begin
			lbn++;
			lbt = tgt;
		end
		if (pf === 1'b1) begin
			pfn++;
			pft = pfa;
		end
		if (ncyc == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		sel <= 4'h0;
	endtask
	// Write then count stall cycles over a window longer than any replay
	task automatic wst(input logic [7:0] a, input logic [31:0] d, input int exp);
		wb(1, a, d);
		stn = 0;
		repeat (14) @(posedge clk);
		chk(stn, exp);
	endtask
	task automatic setup(input logic u, input logic [31:0] t, b, c, f);
		@(posedge clk);
		su <= '{1'b1, u, t, b, c, f};
		@(posedge clk);
		su.valid <= 0;
	endtask
	task automatic run(input logic [31:0] s, e);
		@(posedge clk);
		st <= s; en <= e;
		@(posedge clk);
		go <= 1; lbn = 0; stn = 0; pfn = 0;
		do @(posedge clk); while (done !== 1'b1);
		go <= 0;
	endtask
	task automatic t_reset;
		for (int a = 0; a < 32; a += 4) begin
			wb(0, a[7:0], 0);
			chk(q, 32'h0);
		end
	endtask
	task automatic t_single;
		setup(0, 32'h100, 32'h104, 32'h3, 32'h100);
		run(32'h100, 32'h108);
		chk(lbn, 2);
		chk(stn, 0);
		wb(0, 8'h00, 0);
		chk(q, 32'h0);
		wb(0, 8'h04, 0);
		chk(q, 32'h100);
		wb(0, 8'h08, 0);
		chk(q, 32'h104);
		@(posedge clk);
		freq <= 1; fadr <= 32'h104;
		@(posedge clk);
		freq <= 0;
		@(posedge clk);
		chk(hit, 32'h1);
		chk(bdat, 32'ha5a5_0104);
		run(32'h100, 32'h108);
		chk(lbn, 0);
	endtask
	task automatic t_nested;
		setup(0, 32'h100, 32'h10c, 32'h2, 32'h100);
		setup(1, 32'h108, 32'h10c, 32'h3, 32'h108);
		run(32'h108, 32'h110);
		chk(lbn, 3);
		chk(lbt, 32'h100);
		wb(0, 8'h00, 0);
		chk(q, 32'h0);
	endtask
	task automatic t_offset;
		setup(0, 32'h200, 32'h214, 32'h3, 32'h1f8);
		run(32'h200, 32'h218);
		chk(stn, 4);
		chk(pfn, 2);
		chk(pft, 32'h210);
	endtask
	// Branch at the bottom: no implicit jump, count still steps down
	task automatic t_branch;
		setup(0, 32'h100, 32'h104, 32'h3, 32'h100);
		redir <= 1;
		run(32'h100, 32'h108);
		redir <= 0;
		chk(lbn, 0);
		wb(0, 8'h00, 0);
		chk(q, 32'h2);
	endtask
	task automatic t_regs;
		wst(8'h00, 32'h5, 10);
		wb(0, 8'h00, 0);
		chk(q, 32'h5);
		wst(8'h04, 32'h300, 10);
		wst(8'h0c, 32'h0, 10);
		wst(8'h10, 32'h44, 0);
		wb(0, 8'h10, 0);
		chk(q, 32'h44);
		wst(8'h0c, 32'hffff_ffff, 10);
		wb(0, 8'h0c, 0);
		chk(q, 32'hffff_ffff);
		wst(8'h1c, 32'h7, 0);
		wb(0, 8'h1c, 0);
		chk(q, 32'h0);
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_single;
		t_nested;
		t_offset;
		t_branch;
		t_regs;
		tally_and_finish;
	end
endmodule
`default_nettype wire
